// ---- rtl/dtd_defines.vh ----
// Constants for the data transfer decode and timing block.
// Assumes inclusion by bare name from the rtl directory.
`ifndef DTD_DEFINES_VH
`define DTD_DEFINES_VH

// ----------------------------------------------------------------
// Opcode patterns
// ----------------------------------------------------------------
`define DTD_OP_PREFIX 8'h0f
`define DTD_OP7_MOV_STORE 7'h44
`define DTD_OP7_MOV_LOAD 7'h45
`define DTD_OP7_MOV_IMM 7'h63
`define DTD_OP4_MOV_IMM_SHORT 4'hb
`define DTD_OP7_ACC_LOAD 7'h50
`define DTD_OP7_ACC_STORE 7'h51
`define DTD_OP_SEG_LOAD 8'h8e
`define DTD_OP_SEG_STORE 8'h8c
`define DTD_OP_GROUP_FF 8'hff
`define DTD_OP_PUSH_IMM_MASK 8'hfd
`define DTD_OP_PUSH_IMM 8'h68
`define DTD_OP_SEG_LEGACY_MASK 8'he6
`define DTD_OP_SEG_LEGACY 8'h06
`define DTD_OP2_SIGN_EXT 7'h5f
`define DTD_OP2_ZERO_EXT 7'h5b
`define DTD_OP2_SEG_MASK 8'hc7
`define DTD_OP2_PUSH_SEG 8'h80
`define DTD_OP2_POP_SEG 8'h81
`define DTD_REG_PUSH 3'h6
`define DTD_REG_ZERO 3'h0
`define DTD_MOD_REG 2'h3

// ----------------------------------------------------------------
// Clock counts
// ----------------------------------------------------------------
`define DTD_CNT_W 6
`define DTD_CLK_2 6'h02
`define DTD_CLK_3 6'h03
`define DTD_CLK_4 6'h04
`define DTD_CLK_5 6'h05
`define DTD_CLK_6 6'h06
`define DTD_CLK_7 6'h07
`define DTD_CLK_18 6'h12
`define DTD_CLK_19 6'h13
`define DTD_CLK_21 6'h15
`define DTD_CLK_ONE 6'h01
`define DTD_CLK_ZERO 6'h00
`define DTD_WAIT_W 4

// ----------------------------------------------------------------
// Form codes
// ----------------------------------------------------------------
`define DTD_FORM_W 5
`define DTD_F_NONE 5'h00
`define DTD_F_MOV_STORE 5'h01
`define DTD_F_MOV_LOAD 5'h02
`define DTD_F_MOV_IMM 5'h03
`define DTD_F_MOV_IMM_SHORT 5'h04
`define DTD_F_ACC_LOAD 5'h05
`define DTD_F_ACC_STORE 5'h06
`define DTD_F_SEG_LOAD 5'h07
`define DTD_F_SEG_STORE 5'h08
`define DTD_F_SIGN_EXT 5'h09
`define DTD_F_ZERO_EXT 5'h0a
`define DTD_F_PUSH_RM 5'h0b
`define DTD_F_PUSH_IMM 5'h0c
`define DTD_F_PUSH_SEG 5'h0d
`define DTD_F_POP_SEG_LEGACY 5'h0e
`define DTD_F_POP_SEG_ADDED 5'h0f

`endif

// ---- rtl/dtd_form_decode.v ----
// Combinational classifier of data transfer opcodes into form codes.
// Assumes opcode bytes are already aligned by the prefetch pipeline.
`timescale 1ns/100ps
`default_nettype none
`include "dtd_defines.vh"

module dtd_form_decode (
    input wire [7:0] op_first,
    input wire [7:0] op_second,
    input wire [7:0] op_modrm,
    output reg [`DTD_FORM_W-1:0] form,
    output reg has_modrm
);

    // ------------------------------------------------------------
    // Opcode classification
    // ------------------------------------------------------------
    always @* begin
        form = `DTD_F_NONE;
        has_modrm = 1'b0;
        if (op_first == `DTD_OP_PREFIX) begin
            // Two-byte forms
            if (op_second[7:1] == `DTD_OP2_SIGN_EXT) begin
                form = `DTD_F_SIGN_EXT;
                has_modrm = 1'b1;
            end else if (op_second[7:1] == `DTD_OP2_ZERO_EXT) begin
                form = `DTD_F_ZERO_EXT;
                has_modrm = 1'b1;
            end else if ((op_second & `DTD_OP2_SEG_MASK) == `DTD_OP2_PUSH_SEG) begin
                form = `DTD_F_PUSH_SEG;
            end else if ((op_second & `DTD_OP2_SEG_MASK) == `DTD_OP2_POP_SEG) begin
                form = `DTD_F_POP_SEG_ADDED;
            end
        end else if (op_first[7:1] == `DTD_OP7_MOV_STORE) begin
            form = `DTD_F_MOV_STORE;
            has_modrm = 1'b1;
        end else if (op_first[7:1] == `DTD_OP7_MOV_LOAD) begin
            form = `DTD_F_MOV_LOAD;
            has_modrm = 1'b1;
        end else if (op_first[7:1] == `DTD_OP7_MOV_IMM &&
                     op_modrm[5:3] == `DTD_REG_ZERO) begin
            form = `DTD_F_MOV_IMM;
            has_modrm = 1'b1;
        end else if (op_first[7:4] == `DTD_OP4_MOV_IMM_SHORT) begin
            form = `DTD_F_MOV_IMM_SHORT;
        end else if (op_first[7:1] == `DTD_OP7_ACC_LOAD) begin
            form = `DTD_F_ACC_LOAD;
        end else if (op_first[7:1] == `DTD_OP7_ACC_STORE) begin
            form = `DTD_F_ACC_STORE;
        end else if (op_first == `DTD_OP_SEG_LOAD) begin
            form = `DTD_F_SEG_LOAD;
            has_modrm = 1'b1;
        end else if (op_first == `DTD_OP_SEG_STORE) begin
            form = `DTD_F_SEG_STORE;
            has_modrm = 1'b1;
        end else if (op_first == `DTD_OP_GROUP_FF &&
                     op_modrm[5:3] == `DTD_REG_PUSH) begin
            form = `DTD_F_PUSH_RM;
            has_modrm = 1'b1;
        end else if ((op_first & `DTD_OP_PUSH_IMM_MASK) == `DTD_OP_PUSH_IMM) begin
            form = `DTD_F_PUSH_IMM;
        end else if ((op_first & `DTD_OP_SEG_LEGACY_MASK) == `DTD_OP_SEG_LEGACY) begin
            // Bit 0 picks push (clear) or pop (set)
            if (op_first[0])
                form = `DTD_F_POP_SEG_LEGACY;
            else
                form = `DTD_F_PUSH_SEG;
        end
    end

endmodule // dtd_form_decode
`default_nettype wire

// ---- rtl/dtd_count_table.v ----
// Base clock count lookup per form, mode and operand kind.
// Assumes the form code from the classifier.
`timescale 1ns/100ps
`default_nettype none
`include "dtd_defines.vh"

module dtd_count_table (
    input wire [`DTD_FORM_W-1:0] form,
    input wire protected_mode,
    input wire mem_operand,
    output reg [`DTD_CNT_W-1:0] base_count
);

    // ------------------------------------------------------------
    // Count table
    // ------------------------------------------------------------
    always @* begin
        case (form)
            `DTD_F_MOV_STORE: base_count = `DTD_CLK_2;
            `DTD_F_MOV_LOAD: base_count = mem_operand ? `DTD_CLK_4 : `DTD_CLK_2;
            `DTD_F_MOV_IMM: base_count = `DTD_CLK_2;
            `DTD_F_MOV_IMM_SHORT: base_count = `DTD_CLK_2;
            `DTD_F_ACC_LOAD: base_count = `DTD_CLK_4;
            `DTD_F_ACC_STORE: base_count = `DTD_CLK_2;
            `DTD_F_SEG_LOAD: begin
                // Protected mode reloads descriptor
                if (protected_mode)
                    base_count = mem_operand ? `DTD_CLK_19 : `DTD_CLK_18;
                else
                    base_count = mem_operand ? `DTD_CLK_5 : `DTD_CLK_2;
            end
            `DTD_F_SEG_STORE: base_count = `DTD_CLK_2;
            `DTD_F_SIGN_EXT: base_count = mem_operand ? `DTD_CLK_6 : `DTD_CLK_3;
            `DTD_F_ZERO_EXT: base_count = mem_operand ? `DTD_CLK_6 : `DTD_CLK_3;
            `DTD_F_PUSH_RM: base_count = `DTD_CLK_5;
            `DTD_F_PUSH_IMM: base_count = `DTD_CLK_2;
            `DTD_F_PUSH_SEG: base_count = `DTD_CLK_2;
            `DTD_F_POP_SEG_LEGACY,
            `DTD_F_POP_SEG_ADDED:
                base_count = protected_mode ? `DTD_CLK_21 : `DTD_CLK_7;
            default: base_count = `DTD_CLK_ZERO; // Not this group
        endcase
    end

endmodule // dtd_count_table
`default_nettype wire

// ---- rtl/dtd_decode_timing.v ----
// Top of the data transfer decode and timing block.
// Assumes a decode strobe from the prefetch pipeline with opcode bytes,
// an effective-address hint and the wait states the bus will insert.
`timescale 1ns/100ps
`default_nettype none
`include "dtd_defines.vh"

module dtd_decode_timing (
    input wire mclk,
    input wire sys_rst,
    input wire decode_valid,
    input wire [7:0] op_first,
    input wire [7:0] op_second,
    input wire [7:0] op_modrm,
    input wire protected_mode,
    input wire ea_two_regs,
    input wire [`DTD_WAIT_W-1:0] wait_states,
    output reg result_valid,
    output reg recognized,
    output reg [`DTD_FORM_W-1:0] form_code,
    output reg full_width,
    output reg mem_access,
    output reg [`DTD_CNT_W-1:0] clock_count,
    output reg busy
);

    // ------------------------------------------------------------
    // Internal signals
    // ------------------------------------------------------------
    wire [`DTD_FORM_W-1:0] dec_form; // Classified form
    wire dec_has_modrm; // Form carries addressing byte
    wire [`DTD_CNT_W-1:0] dec_base; // Table count
    reg dec_mem; // Memory operand present
    reg dec_width; // Operand size flag
    reg [`DTD_CNT_W-1:0] next_count; // Total count
    reg [`DTD_CNT_W-1:0] remaining; // Execution countdown

    // ------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------
    dtd_form_decode dtd_form_decode_i (
        .op_first(op_first),
        .op_second(op_second),
        .op_modrm(op_modrm),
        .form(dec_form),
        .has_modrm(dec_has_modrm)
    );

    dtd_count_table dtd_count_table_i (
        .form(dec_form),
        .protected_mode(protected_mode),
        .mem_operand(dec_mem),
        .base_count(dec_base)
    );

    // ------------------------------------------------------------
    // Operand kind and total count
    // ------------------------------------------------------------
    always @* begin
        // Memory when mod field is not register
        if (dec_has_modrm)
            dec_mem = (op_modrm[7:6] != `DTD_MOD_REG);
        else
            dec_mem = (dec_form == `DTD_F_ACC_LOAD) || (dec_form == `DTD_F_ACC_STORE) ||
                      (dec_form == `DTD_F_PUSH_IMM) || (dec_form == `DTD_F_PUSH_SEG) ||
                      (dec_form == `DTD_F_POP_SEG_LEGACY) ||
                      (dec_form == `DTD_F_POP_SEG_ADDED);
        // Size flag position per form
        case (dec_form)
            `DTD_F_MOV_IMM_SHORT: dec_width = op_first[3];
            `DTD_F_SIGN_EXT, `DTD_F_ZERO_EXT: dec_width = op_second[0];
            `DTD_F_MOV_STORE, `DTD_F_MOV_LOAD, `DTD_F_MOV_IMM,
            `DTD_F_ACC_LOAD, `DTD_F_ACC_STORE: dec_width = op_first[0];
            default: dec_width = 1'b1; // Fixed full width
        endcase
        next_count = dec_base;
        // Two-register address costs one clock
        if (dec_has_modrm && dec_mem && ea_two_regs)
            next_count = next_count + `DTD_CLK_ONE;
        // One clock per wait state on data access
        if (dec_mem)
            next_count = next_count + {{(`DTD_CNT_W-`DTD_WAIT_W){1'b0}}, wait_states};
    end

    // ------------------------------------------------------------
    // Result registers and execution countdown
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (sys_rst) begin
            result_valid <= 1'b0;
            recognized <= 1'b0;
            form_code <= `DTD_F_NONE;
            full_width <= 1'b0;
            mem_access <= 1'b0;
            clock_count <= `DTD_CLK_ZERO;
            remaining <= `DTD_CLK_ZERO;
            busy <= 1'b0;
        end else begin
            result_valid <= 1'b0;
            if (decode_valid && !busy) begin
                // Accept a new instruction
                result_valid <= 1'b1;
                recognized <= (dec_form != `DTD_F_NONE);
                form_code <= dec_form;
                full_width <= dec_width;
                mem_access <= dec_mem;
                clock_count <= next_count;
                if (dec_form != `DTD_F_NONE && next_count > `DTD_CLK_ONE) begin
                    remaining <= next_count - `DTD_CLK_ONE;
                    busy <= 1'b1;
                end
            end else if (busy) begin
                // Hold off decode while executing
                remaining <= remaining - `DTD_CLK_ONE;
                if (remaining == `DTD_CLK_ONE)
                    busy <= 1'b0;
            end
        end
    end

endmodule // dtd_decode_timing
`default_nettype wire

// ---- testbench/dtd_timing_sva.sv ----
// Checker for the decode and timing top; sees only the top's ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module dtd_timing_sva (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic decode_valid,
    input wire logic [7:0] op_first,
    input wire logic [7:0] op_second,
    input wire logic [7:0] op_modrm,
    input wire logic protected_mode,
    input wire logic ea_two_regs,
    input wire logic [3:0] wait_states,
    input wire logic result_valid,
    input wire logic recognized,
    input wire logic [4:0] form_code,
    input wire logic full_width,
    input wire logic mem_access,
    input wire logic [5:0] clock_count,
    input wire logic busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic [5:0] busy_run; // Busy cycles since the last answer
    // Count busy cycles, restarting at each answer
    always_ff @(posedge mclk) begin
        if (sys_rst) busy_run <= 6'h00;
        else if (result_valid) busy_run <= {5'h00, busy};
        else busy_run <= busy_run + {5'h00, busy};
    end
    a_valid_pulse: assert property (result_valid |=> !result_valid)
        else $error("result_valid longer than one cycle");
    a_only_taken: assert property (result_valid |-> $past(decode_valid) && !$past(busy))
        else $error("answer without a taken request");
    a_busy_span: assert property ($fell(busy) |-> busy_run == clock_count - 6'h01)
        else $error("busy span differs from clock count");
    a_store_two: assert property (result_valid && $past(op_first[7:1]) == 7'h44
        |-> clock_count == 6'h02 + (($past(op_modrm[7:6]) == 2'h3) ? 6'h00 :
        $past(wait_states) + $past(ea_two_regs)))
        else $error("register store count wrong");
    a_load_wait: assert property (result_valid && $past(op_first[7:1]) == 7'h45 |->
        full_width == $past(op_first[0]) && clock_count == (($past(op_modrm[7:6]) == 2'h3) ?
        6'h02 : 6'h04 + $past(wait_states) + $past(ea_two_regs)))
        else $error("register load count or width wrong");
    a_short_imm: assert property (result_valid && $past(op_first[7:4]) == 4'hb |->
        clock_count == 6'h02 && !mem_access)
        else $error("short immediate count wrong");
    a_acc_load: assert property (result_valid && $past(op_first[7:1]) == 7'h50 |->
        clock_count == 6'h04 + $past(wait_states))
        else $error("accumulator load count wrong");
    a_seg_mode: assert property (result_valid && $past(op_first) == 8'h8e &&
        $past(op_modrm[7:6]) == 2'h3 |-> clock_count == ($past(protected_mode) ? 6'h12 : 6'h02))
        else $error("segment load count wrong");
    a_ext_reg: assert property (result_valid && $past(op_first) == 8'h0f &&
        $past(op_second[7:4]) == 4'hb && $past(op_second[2:1]) == 2'h3 &&
        $past(op_modrm[7:6]) == 2'h3 |-> clock_count == 6'h03)
        else $error("extending load count wrong");
    a_pop_seg: assert property (result_valid &&
        ($past(op_first) & 8'he7) == 8'h07 && $past(op_first) != 8'h0f |->
        clock_count == ($past(protected_mode) ? 6'h15 : 6'h07) + $past(wait_states))
        else $error("segment pop count wrong");
    c_long: cover property (result_valid && busy);
    c_unknown: cover property (result_valid && !recognized);
    c_refused: cover property (decode_valid && busy);
endmodule // dtd_timing_sva
bind dtd_decode_timing dtd_timing_sva dtd_timing_sva_i (.mclk(mclk), .sys_rst(sys_rst),
    .decode_valid(decode_valid), .op_first(op_first), .op_second(op_second),
    .op_modrm(op_modrm), .protected_mode(protected_mode), .ea_two_regs(ea_two_regs),
    .wait_states(wait_states), .result_valid(result_valid), .recognized(recognized),
    .form_code(form_code), .full_width(full_width), .mem_access(mem_access),
    .clock_count(clock_count), .busy(busy));
`default_nettype wire

// ---- testbench/dtd_decode_timing_tb.sv ----
// Self-checking bench for the decode and timing top.
// Assumes the design files under rtl and the checker bound beside it.
`timescale 1ns/100ps
`default_nettype none
module dtd_decode_timing_tb;
    logic mclk = 1'b0, sys_rst = 1'b1, decode_valid = 1'b0;
    logic [7:0] op_first = 8'h00, op_second = 8'h00, op_modrm = 8'h00;
    logic protected_mode = 1'b0, ea_two_regs = 1'b0;
    logic [3:0] wait_states = 4'h0;
    logic result_valid, recognized, full_width, mem_access, busy;
    logic [4:0] form_code;
    logic [5:0] clock_count;
    integer n_errors = 0, checks = 0;
    dtd_decode_timing dtd_decode_timing_i (.mclk(mclk), .sys_rst(sys_rst),
        .decode_valid(decode_valid), .op_first(op_first), .op_second(op_second),
        .op_modrm(op_modrm), .protected_mode(protected_mode), .ea_two_regs(ea_two_regs),
        .wait_states(wait_states), .result_valid(result_valid), .recognized(recognized),
        .form_code(form_code), .full_width(full_width), .mem_access(mem_access),
        .clock_count(clock_count), .busy(busy));
    always #5 mclk = ~mclk; // 100 MHz
    task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", n, exp, got);
            n_errors++;
        end
    endtask
    // One request: bytes, {protected, two regs}, wait states, expected form and count
    task automatic issue(input logic [23:0] b, input logic [1:0] md, input logic [3:0] ws,
                         input logic [4:0] ef, input logic [5:0] ec);
        integer k;
        k = 0;
        @(negedge mclk);
        while (busy !== 1'b0 && k < 300) begin
            @(negedge mclk);
            k++;
        end
        @(posedge mclk);
        decode_valid <= 1'b1;
        {op_first, op_second, op_modrm} <= b;
        {protected_mode, ea_two_regs} <= md;
        wait_states <= ws;
        @(posedge mclk);
        decode_valid <= 1'b0;
        @(negedge mclk);
        chk("result_valid", result_valid, 8'h01);
        chk("recognized", recognized, {7'h00, ef != 5'h00});
        chk("form_code", form_code, ef);
        chk("clock_count", clock_count, ec);
    endtask
    task automatic t_moves;
        issue(24'h8800c0, 2'h0, 4'h3, 5'h01, 6'h02);
        issue(24'h890006, 2'h0, 4'h3, 5'h01, 6'h05);
        chk("full_width", full_width, 8'h01);
        chk("mem_access", mem_access, 8'h01);
        issue(24'h8b00c0, 2'h1, 4'h0, 5'h02, 6'h02);
        chk("mem_access", mem_access, 8'h00);
        issue(24'h8a0000, 2'h1, 4'h0, 5'h02, 6'h05);
        chk("full_width", full_width, 8'h00);
        issue(24'hc600c0, 2'h0, 4'h0, 5'h03, 6'h02);
        issue(24'hb90000, 2'h0, 4'h2, 5'h04, 6'h02);
        chk("mem_access", mem_access, 8'h00);
        issue(24'ha10000, 2'h0, 4'h1, 5'h05, 6'h05);
        issue(24'ha20000, 2'h2, 4'h0, 5'h06, 6'h02);
    endtask
    task automatic t_segment;
        issue(24'h8e00d8, 2'h0, 4'h0, 5'h07, 6'h02);
        issue(24'h8e0018, 2'h0, 4'h0, 5'h07, 6'h05);
        issue(24'h8e00d8, 2'h2, 4'h0, 5'h07, 6'h12);
        issue(24'h8e0018, 2'h3, 4'h1, 5'h07, 6'h15);
        issue(24'h8c0018, 2'h0, 4'h0, 5'h08, 6'h02);
        issue(24'h060000, 2'h0, 4'h2, 5'h0d, 6'h04);
        chk("mem_access", mem_access, 8'h01);
        issue(24'h0fa000, 2'h0, 4'h0, 5'h0d, 6'h02);
        issue(24'h070000, 2'h0, 4'h1, 5'h0e, 6'h08);
        issue(24'h1f0000, 2'h2, 4'h0, 5'h0e, 6'h15);
        issue(24'h0fa100, 2'h2, 4'h0, 5'h0f, 6'h15);
        issue(24'h0f8900, 2'h0, 4'h0, 5'h0f, 6'h07);
    endtask
    task automatic t_extend_push;
        issue(24'h0fbfc0, 2'h0, 4'h0, 5'h09, 6'h03);
        issue(24'h0fbe00, 2'h0, 4'h2, 5'h09, 6'h08);
        issue(24'h0fb6c0, 2'h0, 4'h0, 5'h0a, 6'h03);
        issue(24'h0fb704, 2'h1, 4'h0, 5'h0a, 6'h07);
        issue(24'hff00f0, 2'h0, 4'h0, 5'h0b, 6'h05);
        issue(24'h680000, 2'h0, 4'h1, 5'h0c, 6'h03);
        issue(24'h6a0000, 2'h0, 4'h0, 5'h0c, 6'h02);
    endtask
    // Unknown opcodes, then a request held while busy must be ignored
    task automatic t_refuse;
        issue(24'h900000, 2'h0, 4'h0, 5'h00, 6'h00);
        issue(24'hff00c0, 2'h0, 4'h0, 5'h00, 6'h00);
        chk("busy", busy, 8'h00);
        issue(24'h8e0018, 2'h2, 4'h0, 5'h07, 6'h13);
        @(posedge mclk);
        decode_valid <= 1'b1;
        repeat (6) begin
            @(negedge mclk);
            chk("result_valid", result_valid, 8'h00);
        end
        @(posedge mclk);
        decode_valid <= 1'b0;
    endtask
    task automatic report_and_stop;
        if (n_errors == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        t_moves();
        t_segment();
        t_extend_push();
        t_refuse();
        report_and_stop();
    end
    initial begin
        #100000;
        n_errors++;
        report_and_stop();
    end
endmodule // dtd_decode_timing_tb
`default_nettype wire
